// >>> verilog/mcd_device.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "mcd_params.svh"
module mcd_device
    import mcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    mcd_link_if.dev link,
    input wire logic secLocked,
    input wire logic spinupDisabled,
    input wire logic [15:0] imageSectors,
    input wire logic verifyOk,
    input wire logic reloadFail,
    output logic imgWrValid,
    output logic [22:0] imgWrAddr,
    output logic [31:0] imgWrData,
    output logic imgStore,
    output logic imgActivate,
    output logic spinDown,
    output logic imgPending,
    output logic busy
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic subKnown(input logic [7:0] sub);
        subKnown = (sub == `MCD_SUB_OFS_SAVE) || (sub == `MCD_SUB_SAVE) ||
                   (sub == `MCD_SUB_OFS_DEFER) || (sub == `MCD_SUB_ACTIVATE);
    endfunction

    function automatic logic subUsesOffset(input logic [7:0] sub);
        subUsesOffset = (sub == `MCD_SUB_OFS_SAVE) || (sub == `MCD_SUB_OFS_DEFER);
    endfunction

    function automatic logic [16:0] segEnd(input logic [15:0] ofs, input logic [15:0] cnt);
        segEnd = {1'b0, ofs} + {1'b0, cnt};
    endfunction

    mcd_dev_state_type state_q;
    logic [7:0] sub_q;
    logic [15:0] cnt_q;
    logic [15:0] ofs_q;
    logic [15:0] expOfs_q;
    logic [15:0] secIdx_q;
    logic [`MCD_WORD_IDX_W-1:0] wordIdx_q;
    logic pending_q;
    logic xferReq_q;
    logic doneValid_q;
    logic [7:0] errorReg_q;
    logic imgWrValid_q;
    logic [22:0] imgWrAddr_q;
    logic [31:0] imgWrData_q;
    logic imgStore_q;
    logic imgActivate_q;
    logic spinDown_q;
    logic busy_q;

    logic [7:0] cmdSub;
    logic [15:0] cmdCnt;
    logic [15:0] cmdOfs;
    logic cmdAbort;
    logic ofsBreak;
    logic lastWord;
    logic finalSeg;
    logic doActivate;
    logic finAbort;

    // ------------------------------------------------------------
    // Command field decode
    // ------------------------------------------------------------
    always_comb
    begin
        cmdSub = link.cmdFeature;
        cmdCnt = {link.cmdLba[`MCD_LBA_CNT_HI_LSB +: 8], link.cmdCount};
        cmdOfs = link.cmdLba[`MCD_LBA_OFS_LSB +: 16];
        ofsBreak = subUsesOffset(cmdSub) && (cmdOfs != expOfs_q);
        cmdAbort = (link.cmdOpcode != `MCD_OPC_DL_DMA) || !subKnown(cmdSub) ||
                   secLocked;
        lastWord = link.dataValid && (wordIdx_q == 7'h7F) && (secIdx_q == cnt_q - 16'h0001);
        // Offset-less save carries the whole image in one command
        finalSeg = (sub_q == `MCD_SUB_SAVE) || (subUsesOffset(sub_q) &&
                   (segEnd(ofs_q, cnt_q) >= {1'b0, imageSectors}));
        finAbort = ((sub_q == `MCD_SUB_ACTIVATE) && !pending_q) ||
                   (finalSeg && !verifyOk && sub_q != `MCD_SUB_ACTIVATE);
        doActivate = !finAbort && (((sub_q == `MCD_SUB_ACTIVATE) && pending_q) ||
                     (finalSeg && sub_q != `MCD_SUB_OFS_DEFER &&
                      sub_q != `MCD_SUB_ACTIVATE));
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= DEV_IDLE;
            sub_q <= 8'h00;
            cnt_q <= 16'h0000;
            ofs_q <= 16'h0000;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                DEV_IDLE:
                begin
                    if (link.cmdValid && !cmdAbort && !ofsBreak)
                    begin
                        sub_q <= cmdSub;
                        cnt_q <= cmdCnt;
                        // Offset disregarded outside offset subcommands
                        ofs_q <= subUsesOffset(cmdSub) ? cmdOfs : 16'h0000;
                        state_q <= (cmdCnt == 16'h0000) ? DEV_FIN : DEV_XFER;
                        busy_q <= 1'b1;
                    end
                end
                DEV_XFER:
                begin
                    if (lastWord)
                    begin
                        state_q <= DEV_FIN;
                    end
                end
                DEV_FIN:
                begin
                    state_q <= DEV_IDLE;
                    busy_q <= 1'b0;
                end
                default:
                begin
                    state_q <= DEV_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data counting and image write
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secIdx_q <= 16'h0000;
            wordIdx_q <= 7'h00;
            xferReq_q <= 1'b0;
            imgWrValid_q <= 1'b0;
            imgWrAddr_q <= 23'h000000;
            imgWrData_q <= 32'h00000000;
        end
        else
        begin
            imgWrValid_q <= 1'b0;
            xferReq_q <= (state_q == DEV_XFER) && !lastWord;
            if (state_q == DEV_IDLE)
            begin
                secIdx_q <= 16'h0000;
                wordIdx_q <= 7'h00;
            end
            else if (state_q == DEV_XFER && link.dataValid)
            begin
                wordIdx_q <= wordIdx_q + 7'h01;
                if (wordIdx_q == 7'h7F)
                begin
                    secIdx_q <= secIdx_q + 16'h0001;
                end
                // Activate payload is drained but never written to the image
                imgWrValid_q <= (sub_q != `MCD_SUB_ACTIVATE);
                imgWrAddr_q <= {ofs_q + secIdx_q, wordIdx_q};
                imgWrData_q <= link.dataWord;
            end
        end
    end

    // ------------------------------------------------------------
    // Image session: continuity, pending image, completion
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Reset wipes partial and pending images alike
            expOfs_q <= 16'h0000;
            pending_q <= 1'b0;
            doneValid_q <= 1'b0;
            errorReg_q <= 8'h00;
            imgStore_q <= 1'b0;
            imgActivate_q <= 1'b0;
            spinDown_q <= 1'b0;
        end
        else
        begin
            doneValid_q <= 1'b0;
            imgStore_q <= 1'b0;
            imgActivate_q <= 1'b0;
            spinDown_q <= 1'b0;
            if (state_q == DEV_IDLE && link.cmdValid && (cmdAbort || ofsBreak))
            begin
                doneValid_q <= 1'b1;
                errorReg_q <= 8'h00;
                errorReg_q[`MCD_ERR_ABORT_BIT] <= 1'b1;
                if (ofsBreak && !cmdAbort)
                begin
                    expOfs_q <= 16'h0000;
                    pending_q <= 1'b0;
                end
            end
            else if (state_q == DEV_FIN)
            begin
                doneValid_q <= 1'b1;
                errorReg_q <= 8'h00;
                if (subUsesOffset(sub_q))
                begin
                    expOfs_q <= finalSeg ? 16'h0000 : 16'(segEnd(ofs_q, cnt_q));
                end
                if (finAbort)
                begin
                    errorReg_q[`MCD_ERR_ABORT_BIT] <= 1'b1;
                    pending_q <= 1'b0;
                end
                else
                begin
                    if (finalSeg)
                    begin
                        imgStore_q <= 1'b1;
                        pending_q <= (sub_q == `MCD_SUB_OFS_DEFER);
                    end
                    if (doActivate)
                    begin
                        imgActivate_q <= 1'b1;
                        pending_q <= 1'b0;
                        // Reload failure is only reported when a reload happens
                        errorReg_q[`MCD_ERR_RELOAD_BIT] <= reloadFail;
                        spinDown_q <= spinupDisabled && !reloadFail;
                    end
                end
            end
        end
    end

    assign link.xferReq = xferReq_q;
    assign link.doneValid = doneValid_q;
    assign link.errorReg = errorReg_q;
    assign imgWrValid = imgWrValid_q;
    assign imgWrAddr = imgWrAddr_q;
    assign imgWrData = imgWrData_q;
    assign imgStore = imgStore_q;
    assign imgActivate = imgActivate_q;
    assign spinDown = spinDown_q;
    assign imgPending = pending_q;
    assign busy = busy_q;
endmodule // mcd_device

// >>> verilog/mcd_params.svh
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

`define MCD_OPC_DL_DMA 8'h93
`define MCD_SUB_OFS_SAVE 8'h03
`define MCD_SUB_SAVE 8'h07
`define MCD_SUB_OFS_DEFER 8'h0E
`define MCD_SUB_ACTIVATE 8'h0F
// Sector of 512 bytes moves as 128 words of 32 bits
`define MCD_SECTOR_BYTES 512
`define MCD_WORDS_PER_SECTOR 128
`define MCD_WORD_IDX_W 7
// Address field layout
`define MCD_LBA_CNT_HI_LSB 0
`define MCD_LBA_OFS_LSB 8
// Error register bits
`define MCD_ERR_ABORT_BIT 2
`define MCD_ERR_RELOAD_BIT 6
// Host register byte offsets
`define MCD_REG_CTRL 4'h0
`define MCD_REG_XFER 4'h4
`define MCD_REG_STATUS 4'h8
`define MCD_CTRL_START_BIT 16
`define MCD_STAT_BUSY_BIT 0
`define MCD_STAT_DONE_BIT 1

`endif

// >>> verilog/mcd_pkg.sv
package mcd_pkg;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_XFER = 2'b01,
        DEV_FIN = 2'b10
    } mcd_dev_state_type;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_CMD = 2'b01,
        HST_DATA = 2'b10,
        HST_WAIT = 2'b11
    } mcd_hst_state_type;

endpackage

// >>> verilog/mcd_link_if.sv
`timescale 1ns/1ps
interface mcd_link_if;
    logic cmdValid;
    logic [7:0] cmdOpcode;
    logic [7:0] cmdFeature;
    logic [7:0] cmdCount;
    logic [27:0] cmdLba;
    logic xferReq;
    logic dataValid;
    logic [31:0] dataWord;
    logic doneValid;
    logic [7:0] errorReg;

    modport dev (
        input cmdValid,
        input cmdOpcode,
        input cmdFeature,
        input cmdCount,
        input cmdLba,
        output xferReq,
        input dataValid,
        input dataWord,
        output doneValid,
        output errorReg
    );

    modport host (
        output cmdValid,
        output cmdOpcode,
        output cmdFeature,
        output cmdCount,
        output cmdLba,
        input xferReq,
        output dataValid,
        output dataWord,
        input doneValid,
        input errorReg
    );
endinterface

// >>> verilog/mcd_host.sv
`timescale 1ns/1ps
`include "mcd_params.svh"
module mcd_host
    import mcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    mcd_link_if.host link,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic [31:0] dataIn,
    input wire logic dataInValid,
    output logic dataInAck
);
    // ------------------------------------------------------------
    // Registers and link state
    // ------------------------------------------------------------
    mcd_hst_state_type state_q;
    logic [7:0] opc_q;
    logic [7:0] feat_q;
    logic [15:0] cnt_q;
    logic [15:0] ofs_q;
    logic [22:0] remain_q;
    logic phase_q;
    logic done_q;
    logic [7:0] err_q;
    logic [31:0] rdData_q;
    logic cmdValid_q;
    logic dataValid_q;
    logic [31:0] dataWord_q;
    logic ack_q;
    logic startWr;
    logic sendNow;

    assign startWr = regWr && (regAddr == `MCD_REG_CTRL) && regWrData[`MCD_CTRL_START_BIT] &&
                     (state_q == HST_IDLE);
    // One word per two cycles so the source sees the ack before the next take
    assign sendNow = (state_q == HST_DATA) && link.xferReq && dataInValid && !phase_q &&
                     (remain_q != 23'h000000);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opc_q <= 8'h00;
            feat_q <= 8'h00;
            cnt_q <= 16'h0000;
            ofs_q <= 16'h0000;
        end
        else if (regWr && state_q == HST_IDLE)
        begin
            if (regAddr == `MCD_REG_CTRL)
            begin
                feat_q <= regWrData[7:0];
                opc_q <= regWrData[15:8];
            end
            else if (regAddr == `MCD_REG_XFER)
            begin
                cnt_q <= regWrData[15:0];
                ofs_q <= regWrData[31:16];
            end
        end
    end

    // ------------------------------------------------------------
    // Command and DMA sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= HST_IDLE;
            remain_q <= 23'h000000;
            phase_q <= 1'b0;
            cmdValid_q <= 1'b0;
            dataValid_q <= 1'b0;
            dataWord_q <= 32'h00000000;
            ack_q <= 1'b0;
        end
        else
        begin
            cmdValid_q <= 1'b0;
            dataValid_q <= 1'b0;
            ack_q <= 1'b0;
            case (state_q)
                HST_IDLE:
                begin
                    if (startWr)
                    begin
                        cmdValid_q <= 1'b1;
                        // Whole sectors only
                        remain_q <= {cnt_q, 7'h00};
                        phase_q <= 1'b0;
                        state_q <= HST_CMD;
                    end
                end
                HST_CMD:
                begin
                    state_q <= HST_DATA;
                end
                HST_DATA:
                begin
                    phase_q <= sendNow;
                    if (link.doneValid)
                    begin
                        state_q <= HST_IDLE;
                    end
                    else if (sendNow)
                    begin
                        dataValid_q <= 1'b1;
                        dataWord_q <= dataIn;
                        ack_q <= 1'b1;
                        remain_q <= remain_q - 23'h000001;
                    end
                    else if (remain_q == 23'h000000)
                    begin
                        state_q <= HST_WAIT;
                    end
                end
                HST_WAIT:
                begin
                    if (link.doneValid)
                    begin
                        state_q <= HST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= HST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status and register read
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_q <= 1'b0;
            err_q <= 8'h00;
            rdData_q <= 32'h00000000;
        end
        else
        begin
            // Completion wins over a simultaneous clear
            if (link.doneValid && state_q != HST_IDLE)
            begin
                done_q <= 1'b1;
                err_q <= link.errorReg;
            end
            else if (regWr && regAddr == `MCD_REG_STATUS)
            begin
                done_q <= 1'b0;
            end
            rdData_q <= 32'h00000000;
            if (regRd)
            begin
                case (regAddr)
                    `MCD_REG_CTRL: rdData_q <= {16'h0000, opc_q, feat_q};
                    `MCD_REG_XFER: rdData_q <= {ofs_q, cnt_q};
                    `MCD_REG_STATUS: rdData_q <= {16'h0000, err_q, 6'h00, done_q,
                                                  state_q != HST_IDLE};
                    default: rdData_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign link.cmdValid = cmdValid_q;
    assign link.cmdOpcode = opc_q;
    assign link.cmdFeature = feat_q;
    assign link.cmdCount = cnt_q[7:0];
    // Reserved address bits 27:24 sent as zero; first segment offset set by software
    assign link.cmdLba = {4'h0, ofs_q, cnt_q[15:8]};
    assign link.dataValid = dataValid_q;
    assign link.dataWord = dataWord_q;
    assign regRdData = rdData_q;
    assign dataInAck = ack_q;
endmodule // mcd_host

// >>> test/mcd_link_checker.sv
`timescale 1ns/1ps
module mcd_link_checker
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    input wire logic [7:0] cmdFeature,
    input wire logic [7:0] cmdCount,
    input wire logic [27:0] cmdLba,
    input wire logic xferReq,
    input wire logic dataValid,
    input wire logic doneValid,
    input wire logic [7:0] errorReg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] subQ;
    logic subOk;
    assign subOk = cmdFeature inside {8'h03, 8'h07, 8'h0E, 8'h0F};
    // Subcommand of the command in flight
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            subQ <= 8'h00;
        else if (cmdValid)
            subQ <= cmdFeature;
    end
    bad_opcode_a: assert property (cmdValid && cmdOpcode != 8'h93 |=> doneValid && errorReg[2])
        else $error("foreign opcode not aborted");
    bad_sub_a: assert property (cmdValid && !subOk |=> doneValid && errorReg[2])
        else $error("reserved subcommand not aborted");
    zero_count_a: assert property (cmdValid && cmdOpcode == 8'h93 && subOk &&
        {cmdLba[7:0], cmdCount} == 16'h0000 |=> !xferReq [*3])
        else $error("data requested for zero count");
    reserved_lba_a: assert property (cmdValid |-> cmdLba[27:24] == 4'h0)
        else $error("reserved address bits set");
    done_pulse_a: assert property (doneValid |=> !doneValid)
        else $error("completion longer than one cycle");
    err_hold_a: assert property (!doneValid |-> $stable(errorReg))
        else $error("error register moved between completions");
    defer_reload_a: assert property (doneValid && subQ == 8'h0E |-> !errorReg[6])
        else $error("reload failure without reload");
    xfer_start_a: assert property ($rose(xferReq) |-> $past(cmdValid, 2))
        else $error("transfer without command");
    xfer_end_a: assert property ($fell(xferReq) |-> $past(dataValid) ##1 doneValid)
        else $error("transfer end not tied to last word");
    data_in_xfer_a: assert property (dataValid |-> xferReq)
        else $error("word sent outside transfer");
    cover property (doneValid && errorReg[2]);
    cover property ($rose(xferReq));
    cover property (doneValid && errorReg[6]);
endmodule // mcd_link_checker

// >>> test/mcd_tb.sv
`timescale 1ns/1ps
`include "mcd_params.svh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin fails++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic secLocked, spinupDisabled, verifyOk, reloadFail;
    logic [15:0] imageSectors;
    logic imgWrValid, imgStore, imgActivate, spinDown, imgPending, busy;
    logic [22:0] imgWrAddr;
    logic [31:0] imgWrData, regWrData, regRdData, dataIn, rd;
    logic [3:0] regAddr;
    logic regWr, regRd, dataInValid, dataInAck;
    logic doneSeen, storeSeen, actSeen, spinSeen, pendM;
    logic [7:0] errSeen;
    logic [31:0] wordQ[$];
    int fails = 0;
    int checked = 0;
    int seed = 32'h435e;
    int wordIdx, curOfs, nxt;

    always #12.5 core_clk = ~core_clk;

    mcd_link_if link();
    mcd_device mcd_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link),
        .secLocked(secLocked), .spinupDisabled(spinupDisabled), .imageSectors(imageSectors),
        .verifyOk(verifyOk), .reloadFail(reloadFail), .imgWrValid(imgWrValid),
        .imgWrAddr(imgWrAddr), .imgWrData(imgWrData), .imgStore(imgStore),
        .imgActivate(imgActivate), .spinDown(spinDown), .imgPending(imgPending), .busy(busy));
    mcd_host mcd_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .dataIn(dataIn), .dataInValid(dataInValid), .dataInAck(dataInAck));
    mcd_link_checker mcd_link_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
        .cmdValid(link.cmdValid), .cmdOpcode(link.cmdOpcode), .cmdFeature(link.cmdFeature),
        .cmdCount(link.cmdCount), .cmdLba(link.cmdLba), .xferReq(link.xferReq),
        .dataValid(link.dataValid), .doneValid(link.doneValid), .errorReg(link.errorReg));

    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (dataInAck)
        begin
            wordQ.push_back(dataIn);
            dataIn <= $random(seed);
        end
        if (imgWrValid)
        begin
            `CHK(imgWrData, wordQ.pop_front(), "image word")
            `CHK(busy, 1'b1, "busy in transfer")
            `CHK(imgWrAddr, {16'(curOfs + wordIdx / 128), 7'(wordIdx % 128)}, "addr")
            wordIdx++;
        end
        if (link.doneValid)
        begin
            doneSeen = 1'b1;
            errSeen = link.errorReg;
        end
        storeSeen = storeSeen | imgStore;
        actSeen = actSeen | imgActivate;
        spinSeen = spinSeen | spinDown;
        // Source stalls now and then to exercise the host's wait
        dataInValid <= ($random(seed) & 3) != 0;
    end

    // ----------------------------------------
    // Expectation and bus tasks
    // ----------------------------------------
    function automatic void predict(input logic [7:0] op, sub, input logic [15:0] cnt, ofs,
        output logic [7:0] err, output logic [3:0] fl, output int words);
        err = 8'h00;
        fl = 4'h0;
        words = 0;
        if (secLocked || op != `MCD_OPC_DL_DMA || !(sub inside {8'h03, 8'h07, 8'h0E, 8'h0F}))
            err[`MCD_ERR_ABORT_BIT] = 1'b1;
        else if (sub == `MCD_SUB_ACTIVATE)
        begin
            err[`MCD_ERR_ABORT_BIT] = !pendM;
            fl[2] = pendM;
            pendM = 1'b0;
        end
        else if (sub != `MCD_SUB_SAVE && ofs != nxt)
        begin
            err[`MCD_ERR_ABORT_BIT] = 1'b1;
            nxt = 0;
            pendM = 1'b0;
        end
        else
        begin
            words = cnt * `MCD_WORDS_PER_SECTOR;
            nxt = (sub == `MCD_SUB_SAVE) ? imageSectors : ofs + cnt;
            if (nxt >= imageSectors)
            begin
                nxt = 0;
                err[`MCD_ERR_ABORT_BIT] = !verifyOk;
                fl[3] = verifyOk;
                fl[2] = verifyOk && sub != `MCD_SUB_OFS_DEFER;
                // A finished image replaces any deferred one
                pendM = verifyOk && sub == `MCD_SUB_OFS_DEFER;
            end
        end
        if (fl[2])
        begin
            err[`MCD_ERR_RELOAD_BIT] = reloadFail;
            fl[0] = spinupDisabled && !reloadFail;
        end
        fl[1] = pendM;
    endfunction

    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic runCmd(input logic [7:0] op, sub, input logic [15:0] cnt, ofs);
        logic [7:0] err;
        logic [3:0] fl;
        int words;
        int n;
        {doneSeen, storeSeen, actSeen, spinSeen} = 4'h0;
        wordIdx = 0;
        curOfs = (sub == `MCD_SUB_SAVE) ? 0 : ofs;
        regWrite(`MCD_REG_XFER, {ofs, cnt});
        regWrite(`MCD_REG_CTRL, {15'h0000, 1'b1, op, sub});
        predict(op, sub, cnt, ofs, err, fl, words);
        n = 0;
        while (doneSeen !== 1'b1 && n < 40000)
        begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        #1;
        `CHK(errSeen, err, "error register")
        `CHK(storeSeen, fl[3], "image store")
        `CHK(actSeen, fl[2], "activation")
        `CHK(imgPending, fl[1], "pending image")
        `CHK(spinSeen, fl[0], "spin down")
        `CHK(wordIdx, words, "word count")
        `CHK({doneSeen, busy}, 2'b10, "completion")
        regRead(`MCD_REG_STATUS, rd);
        `CHK(rd[15:8], err, "status error field")
        `CHK(rd[1:0], 2'b10, "status done")
        regWrite(`MCD_REG_STATUS, 32'h0000_0000);
        $display("test op %h sub %h count %0d offset %0d ended", op, sub, cnt, ofs);
    endtask

    task automatic pulseReset();
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        nxt = 0;
        pendM = 1'b0;
        @(posedge core_clk);
    endtask

    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        {secLocked, verifyOk, reloadFail, spinupDisabled} = 4'b0101;
        imageSectors = 16'h0003;
        {regAddr, regWrData, regWr, regRd} = '0;
        dataIn = $random(seed);
        dataInValid = 1'b1;
        nxt = 0;
        pendM = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        runCmd(8'h92, 8'h03, 16'h0001, 16'h0000);
        repeat (4) runCmd(8'h93, 8'($random(seed)) | 8'h10, 16'h0001, 16'h0000);
        secLocked <= 1'b1;
        runCmd(8'h93, 8'h07, 16'h0001, 16'h0000);
        secLocked <= 1'b0;
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0000);
        runCmd(8'h93, 8'h03, 16'h0002, 16'h0001);
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0000);
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0002);
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0001);
        runCmd(8'h93, 8'h0E, 16'h0000, 16'h0000);
        repeat (2) runCmd(8'h93, 8'h0E, 16'(1 + ($random(seed) & 1)), 16'(nxt));
        runCmd(8'h93, 8'h0E, 16'(3 - nxt), 16'(nxt));
        reloadFail <= 1'b1;
        runCmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
        reloadFail <= 1'b0;
        runCmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
        verifyOk <= 1'b0;
        runCmd(8'h93, 8'h07, 16'h0001, 16'h0005);
        verifyOk <= 1'b1;
        spinupDisabled <= 1'b0;
        runCmd(8'h93, 8'h07, 16'h0002, 16'h0005);
        runCmd(8'h93, 8'h0E, 16'h0003, 16'h0000);
        pulseReset();
        `CHK(imgPending, 1'b0, "pending after reset")
        runCmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0000);
        pulseReset();
        runCmd(8'h93, 8'h03, 16'h0001, 16'h0001);
        regRead(4'hC, rd);
        `CHK(rd, 32'h0000_0000, "unmapped read")
        close_out();
    end

    initial
    begin
        #(25 * 60000);
        fails++;
        close_out();
    end
endmodule // tb
